/* File: ptu_top.sv */
// six channel 16-bit pulse timer unit with apb register access
`timescale 1ns/1ps
module ptu_top (
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [8:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [3:0] EXT_CLOCK_IN,
  input wire logic [15:0] CAPOUT_PIN_IN,
  output logic [15:0] CAPOUT_PIN_OUT,
  output logic [15:0] CAPOUT_PIN_OE_OUT,
  output logic [25:0] IRQ_FLAGS_OUT,
  output logic IRQ_REQ_OUT,
  output logic [4:0] IRQ_SRC_OUT,
  output logic [15:0] XFER_REQ_OUT,
  output logic ADC_TRIG_OUT
);
  // channels 0 and 3 carry four general registers, the others two
  function automatic logic has4(input logic [2:0] ch);
    return (ch == 3'h0) || (ch == 3'h3);
  endfunction

  function automatic logic [3:0] pin_of(input logic [2:0] ch,
                                        input logic [1:0] g);
    logic [3:0] base;
    case (ch)
      3'h0: base = 4'h0;
      3'h1: base = 4'h4;
      3'h2: base = 4'h6;
      3'h3: base = 4'h8;
      3'h4: base = 4'hC;
      default: base = 4'hE;
    endcase
    return base + {2'h0, g};
  endfunction

  function automatic ptu_pkg::ptu_io_s io_of(input logic [15:0] w,
                                            input logic [1:0] g);
    return w[{g, 2'h0} +: 4];
  endfunction

  function automatic logic apply(input logic [1:0] act, input logic cur);
    case (act)
      ptu_pkg::OUT_LOW: return 1'b0;
      ptu_pkg::OUT_HIGH: return 1'b1;
      ptu_pkg::OUT_TOGGLE: return ~cur;
      default: return cur;
    endcase
  endfunction

  // quadrature decode, returns {up, down}
  function automatic logic [1:0] phase_dir(input logic [1:0] v,
      input logic a, input logic b, input logic ar, input logic af,
      input logic br, input logic bf);
    logic u;
    logic d;
    u = 1'b0;
    d = 1'b0;
    case (v)
      2'h0: begin
        u = (a & br) | (~a & bf) | (~b & ar) | (b & af);
        d = (a & bf) | (~a & br) | (b & ar) | (~b & af);
      end
      2'h1: begin
        u = b & af;
        d = ~b & af;
      end
      2'h2: begin
        u = b & af;
        d = a & bf;
      end
      default: begin
        u = a & br;
        d = a & bf;
      end
    endcase
    return {u, d};
  endfunction

  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [15:0] count_r [0:5];
  logic [15:0] greg_r [0:5][0:3];
  ptu_pkg::ptu_ctrl_s ctrl_r [0:5];
  logic [15:0] ioc_r [0:5];
  logic [5:0] flags_r [0:5];
  logic [5:0] inten_r [0:5];
  logic [5:0] start_r;
  logic [5:0] adc_en_r;
  logic [19:0] s1_r, s2_r, s3_r, flt_r;
  logic [15:0] pin_r, oe_r, pin_nxt, oe_nxt;
  logic [25:0] src_nxt, irq_flags_r;
  logic [15:0] xfer_nxt, xfer_r;
  logic [4:0] top_nxt, irq_src_r;
  logic irq_req_r, adc_r;
  logic [5:0] up, dn, ovf, udf, clr;
  logic [3:0] mat [0:5];
  logic [3:0] cap [0:5];
  logic [19:0] agree, chg, rise, fall;
  logic setup, wr_ok, mapped, sync_any;
  logic [2:0] a_ch;
  logic [3:0] a_rg;
  logic [31:0] rd_data;

  // three stage synchroniser on pins and external clocks
  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      s1_r <= 20'h00000;
      s2_r <= 20'h00000;
      s3_r <= 20'h00000;
      flt_r <= 20'h00000;
    end else begin
      s1_r <= {EXT_CLOCK_IN, CAPOUT_PIN_IN};
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= (agree & s3_r) | (~agree & flt_r);
    end
  end

  // a change counts once stages two and three agree
  assign agree = ~(s2_r ^ s3_r);
  assign chg = agree & (s3_r ^ flt_r);
  assign rise = chg & s3_r;
  assign fall = chg & ~s3_r;

  // apb decode
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign a_ch = PADDR_IN[8:6];
  assign a_rg = PADDR_IN[5:2];
  assign wr_ok = PSEL_IN & PENABLE_IN & pready_r & PWRITE_IN & mapped;

  // read mux and address map check
  always_comb begin
    rd_data = 32'h0000_0000;
    mapped = 1'b0;
    if (a_ch == ptu_pkg::CH_GLOBAL) begin
      mapped = (a_rg == ptu_pkg::R_START);
      rd_data = {18'h00000, adc_en_r, 2'h0, start_r};
    end else if (a_ch < ptu_pkg::CH_GLOBAL) begin
      mapped = (a_rg <= ptu_pkg::R_INTEN);
      case (a_rg)
        ptu_pkg::R_CTRL: rd_data = {19'h00000, ctrl_r[a_ch]};
        ptu_pkg::R_IOCTL: rd_data = {16'h0000, ioc_r[a_ch]};
        ptu_pkg::R_COUNT: rd_data = {16'h0000, count_r[a_ch]};
        ptu_pkg::R_GRA, ptu_pkg::R_GRB: begin
          rd_data = {16'h0000, greg_r[a_ch][a_rg[1:0] + 2'h1]};
        end
        ptu_pkg::R_GRC, ptu_pkg::R_GRD: begin
          mapped = has4(a_ch);
          // index 5 and 6 wrap onto slots 2 and 3
          rd_data = {16'h0000, greg_r[a_ch][a_rg[1:0] + 2'h1]};
        end
        ptu_pkg::R_STATUS: rd_data = {26'h0000000, flags_r[a_ch]};
        ptu_pkg::R_INTEN: rd_data = {26'h0000000, inten_r[a_ch]};
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= ptu_pkg::RDATA_RST;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup) begin
        prdata_r <= mapped ? rd_data : ptu_pkg::RDATA_RST;
      end
    end
  end

  // count sources: internal, external clock, quadrature, cascade
  always_comb begin
    logic [1:0] pd;
    logic [4:0] pa;
    logic [2:0] sm1;
    pd = 2'h0;
    pa = 5'h10;
    sm1 = 3'h0;
    up = 6'h00;
    dn = 6'h00;
    for (int i = 0; i < ptu_pkg::NCH; i++) begin
      pa = (i == 2 || i == 4) ? 5'h12 : 5'h10;
      pd = phase_dir(ctrl_r[i].phase, flt_r[pa], flt_r[pa + 5'h01],
                     rise[pa], fall[pa], rise[pa + 5'h01],
                     fall[pa + 5'h01]);
      sm1 = ctrl_r[i].clk_sel - 3'h1;
      if (!start_r[i]) begin
        up[i] = 1'b0;
      end else if (ctrl_r[i].mode == ptu_pkg::MODE_PHASE &&
                   !has4(3'(i))) begin
        {up[i], dn[i]} = pd;
      end else if (ctrl_r[i].clk_sel == ptu_pkg::CLK_INT) begin
        up[i] = 1'b1;
      end else if (ctrl_r[i].clk_sel <= ptu_pkg::CLK_EXT_D) begin
        up[i] = rise[{3'h4, sm1[1:0]}];
      end
    end
    // channels 1 and 4 count on partner overflow/underflow
    for (int i = 1; i < ptu_pkg::NCH; i += 3) begin
      if (start_r[i] && ctrl_r[i].clk_sel == ptu_pkg::CLK_CASCADE &&
          ctrl_r[i].mode != ptu_pkg::MODE_PHASE) begin
        up[i] = up[i + 1] && count_r[i + 1] == ptu_pkg::COUNT_MAX;
        dn[i] = dn[i + 1] && count_r[i + 1] == ptu_pkg::COUNT_RST;
      end
    end
  end

  // compare matches, captures, wrap events and clear requests
  always_comb begin
    ptu_pkg::ptu_io_s io;
    logic [3:0] p;
    logic [5:0] own;
    io = 4'h0;
    p = 4'h0;
    own = 6'h00;
    for (int i = 0; i < ptu_pkg::NCH; i++) begin
      ovf[i] = up[i] && count_r[i] == ptu_pkg::COUNT_MAX;
      udf[i] = dn[i] && count_r[i] == ptu_pkg::COUNT_RST && !has4(3'(i));
      for (int g = 0; g < 4; g++) begin
        io = io_of(ioc_r[i], 2'(g));
        p = pin_of(3'(i), 2'(g));
        mat[i][g] = (g < 2 || has4(3'(i))) && !io.capture &&
                    (up[i] | dn[i]) && count_r[i] == greg_r[i][g];
        cap[i][g] = (g < 2 || has4(3'(i))) && io.capture &&
                    ((io.act[0] & rise[p]) | (io.act[1] & fall[p]));
      end
      own[i] = ctrl_r[i].clr_sel != ptu_pkg::CLR_NONE &&
               ctrl_r[i].clr_sel <= ptu_pkg::CLR_GRD &&
               (mat[i][ctrl_r[i].clr_sel[1:0] - 2'h1] |
                cap[i][ctrl_r[i].clr_sel[1:0] - 2'h1]);
    end
    sync_any = 1'b0;
    for (int i = 0; i < ptu_pkg::NCH; i++) begin
      sync_any = sync_any | (own[i] & ctrl_r[i].sync);
    end
    for (int i = 0; i < ptu_pkg::NCH; i++) begin
      clr[i] = own[i] | (ctrl_r[i].sync & sync_any);
    end
  end

  // counters, configuration and start bits
  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      start_r <= 6'h00;
      adc_en_r <= 6'h00;
      for (int i = 0; i < ptu_pkg::NCH; i++) begin
        count_r[i] <= ptu_pkg::COUNT_RST;
        ctrl_r[i] <= ptu_pkg::CTRL_RST;
        ioc_r[i] <= ptu_pkg::IOCTL_RST;
        inten_r[i] <= ptu_pkg::FLAGS_RST;
      end
    end else begin
      if (wr_ok && a_ch == ptu_pkg::CH_GLOBAL) begin
        start_r <= PWDATA_IN[ptu_pkg::START_LSB +: 6];
        adc_en_r <= PWDATA_IN[ptu_pkg::ADC_EN_LSB +: 6];
      end
      for (int i = 0; i < ptu_pkg::NCH; i++) begin
        if (wr_ok && a_ch == 3'(i)) begin
          if (a_rg == ptu_pkg::R_CTRL) ctrl_r[i] <= PWDATA_IN[12:0];
          if (a_rg == ptu_pkg::R_IOCTL) ioc_r[i] <= PWDATA_IN[15:0];
          if (a_rg == ptu_pkg::R_INTEN) inten_r[i] <= PWDATA_IN[5:0];
        end
        // a write to a synchronised counter loads the whole group
        if (wr_ok && a_rg == ptu_pkg::R_COUNT &&
            (a_ch == 3'(i) ||
             (ctrl_r[i].sync && a_ch < ptu_pkg::CH_GLOBAL &&
              ctrl_r[a_ch].sync))) begin
          count_r[i] <= PWDATA_IN[15:0];
        end else if (clr[i]) begin
          count_r[i] <= ptu_pkg::COUNT_RST;
        end else if (up[i]) begin
          count_r[i] <= count_r[i] + 16'h0001;
        end else if (dn[i]) begin
          count_r[i] <= count_r[i] - 16'h0001;
        end
      end
    end
  end

  // general registers with capture and buffer transfers
  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      for (int i = 0; i < ptu_pkg::NCH; i++) begin
        for (int g = 0; g < 4; g++) begin
          greg_r[i][g] <= ptu_pkg::GREG_RST;
        end
      end
    end else begin
      for (int i = 0; i < ptu_pkg::NCH; i++) begin
        for (int g = 0; g < 4; g++) begin
          if (wr_ok && a_ch == 3'(i) &&
              a_rg == ptu_pkg::R_GRA + 4'(g)) begin
            greg_r[i][g] <= PWDATA_IN[15:0];
          end else if (g >= 2 && has4(3'(i)) && cap[i][g ^ 2] &&
                       (g == 2 ? ctrl_r[i].buf_a : ctrl_r[i].buf_b)) begin
            greg_r[i][g] <= greg_r[i][g ^ 2];
          end else if (cap[i][g]) begin
            greg_r[i][g] <= count_r[i];
          end else if (g < 2 && has4(3'(i)) && mat[i][g] &&
                       (g == 0 ? ctrl_r[i].buf_a : ctrl_r[i].buf_b)) begin
            greg_r[i][g] <= greg_r[i][g ^ 2];
          end
        end
      end
    end
  end

  // pin levels and drive enables for normal and pwm modes
  always_comb begin
    ptu_pkg::ptu_io_s io;
    ptu_pkg::ptu_io_s io2;
    logic [3:0] p;
    io = 4'h0;
    io2 = 4'h0;
    p = 4'h0;
    pin_nxt = pin_r;
    oe_nxt = 16'h0000;
    for (int i = 0; i < ptu_pkg::NCH; i++) begin
      for (int g = 0; g < 4; g++) begin
        if (g < 2 || has4(3'(i))) begin
          io = io_of(ioc_r[i], 2'(g));
          io2 = io_of(ioc_r[i], 2'(g + 1));
          p = pin_of(3'(i), 2'(g));
          case (ctrl_r[i].mode)
            ptu_pkg::MODE_PWM1: begin
              if (g % 2 == 0) begin
                oe_nxt[p] = 1'b1;
                if (mat[i][g]) pin_nxt[p] = apply(io.act, pin_r[p]);
                if (mat[i][g + 1]) begin
                  pin_nxt[p] = apply(io2.act, pin_nxt[p]);
                end
              end
            end
            ptu_pkg::MODE_PWM2: begin
              if (3'(g + 1) != ctrl_r[i].clr_sel) begin
                oe_nxt[p] = 1'b1;
                if (clr[i]) pin_nxt[p] = io.init_lvl;
                else if (mat[i][g]) pin_nxt[p] = apply(io.act, pin_r[p]);
              end
            end
            default: begin
              oe_nxt[p] = !io.capture && io.act != ptu_pkg::OUT_NONE;
              if (mat[i][g]) pin_nxt[p] = apply(io.act, pin_r[p]);
            end
          endcase
          if (wr_ok && a_ch == 3'(i) && a_rg == ptu_pkg::R_IOCTL) begin
            pin_nxt[p] = PWDATA_IN[g * 4 + 2];
          end
        end
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      pin_r <= 16'h0000;
      oe_r <= 16'h0000;
    end else begin
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
    end
  end

  // sticky flags: hardware set wins over write-one-to-clear
  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      for (int i = 0; i < ptu_pkg::NCH; i++) begin
        flags_r[i] <= ptu_pkg::FLAGS_RST;
      end
    end else begin
      for (int i = 0; i < ptu_pkg::NCH; i++) begin
        flags_r[i] <= (flags_r[i] &
                       ~((wr_ok && a_ch == 3'(i) &&
                          a_rg == ptu_pkg::R_STATUS) ? PWDATA_IN[5:0]
                                                     : 6'h00)) |
                      {udf[i], ovf[i], mat[i] | cap[i]};
      end
    end
  end

  // request vector in reset priority order, channel 0 first
  always_comb begin
    int k;
    int t;
    k = 0;
    t = 0;
    src_nxt = 26'h0000000;
    xfer_nxt = 16'h0000;
    top_nxt = 5'h00;
    for (int i = 0; i < ptu_pkg::NCH; i++) begin
      for (int g = 0; g < 4; g++) begin
        if (g < 2 || has4(3'(i))) begin
          src_nxt[k] = flags_r[i][g] & inten_r[i][g];
          xfer_nxt[t] = flags_r[i][g] & inten_r[i][g];
          k = k + 1;
          t = t + 1;
        end
      end
      src_nxt[k] = flags_r[i][ptu_pkg::FLG_OVF] & inten_r[i][ptu_pkg::FLG_OVF];
      k = k + 1;
      if (!has4(3'(i))) begin
        src_nxt[k] = flags_r[i][ptu_pkg::FLG_UDF] &
                     inten_r[i][ptu_pkg::FLG_UDF];
        k = k + 1;
      end
    end
    for (int s = ptu_pkg::NSRC - 1; s >= 0; s--) begin
      if (src_nxt[s]) top_nxt = 5'(s);
    end
  end

  // registered request and trigger outputs
  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      irq_flags_r <= 26'h0000000;
      irq_req_r <= 1'b0;
      irq_src_r <= 5'h00;
      xfer_r <= 16'h0000;
      adc_r <= 1'b0;
    end else begin
      irq_flags_r <= src_nxt;
      irq_req_r <= |src_nxt;
      irq_src_r <= top_nxt;
      xfer_r <= xfer_nxt;
      adc_r <= |(adc_en_r & {mat[5][0] | cap[5][0], mat[4][0] | cap[4][0],
                             mat[3][0] | cap[3][0], mat[2][0] | cap[2][0],
                             mat[1][0] | cap[1][0],
                             mat[0][0] | cap[0][0]});
    end
  end

  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = pready_r;
  assign PSLVERR_OUT = pslverr_r;
  assign CAPOUT_PIN_OUT = pin_r;
  assign CAPOUT_PIN_OE_OUT = oe_r;
  assign IRQ_FLAGS_OUT = irq_flags_r;
  assign IRQ_REQ_OUT = irq_req_r;
  assign IRQ_SRC_OUT = irq_src_r;
  assign XFER_REQ_OUT = xfer_r;
  assign ADC_TRIG_OUT = adc_r;

  // checks on the guarded behaviour
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);

  property p_wrap;
    up[0] && !dn[0] && !clr[0] && !wr_ok && count_r[0] == 16'hFFFF
      |=> count_r[0] == 16'h0000 && flags_r[0][4];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("no wrap on overflow");
  property p_buf_cmp;
    ctrl_r[0].buf_a && mat[0][0] && !wr_ok
      |=> greg_r[0][0] == $past(greg_r[0][2]);
  endproperty
  a_buf_cmp: assert property (p_buf_cmp)
    else $error("no reload");
  property p_buf_cap;
    ctrl_r[3].buf_a && cap[3][0] && !wr_ok
      |=> greg_r[3][2] == $past(greg_r[3][0]) &&
          greg_r[3][0] == $past(count_r[3]);
  endproperty
  a_buf_cap: assert property (p_buf_cap)
    else $error("bad shift");
  // pin a of channel 0 set high by its own match
  property p_out_high;
    ctrl_r[0].mode == ptu_pkg::MODE_NORMAL && mat[0][0] &&
      ioc_r[0][3:0] == 4'h2 && !wr_ok |=> CAPOUT_PIN_OUT[0];
  endproperty
  a_out_high: assert property (p_out_high)
    else $error("pin not high");
  property p_clear;
    clr[1] && !wr_ok |=> count_r[1] == 16'h0000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("count not cleared");
  property p_capture;
    cap[1][0] && !wr_ok |=> greg_r[1][0] == $past(count_r[1]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("no capture");
  property p_no_udf;
    1'b1 |-> !flags_r[0][5] && !flags_r[3][5];
  endproperty
  a_no_udf: assert property (p_no_udf)
    else $error("udf on ch0/3");
  property p_sticky;
    flags_r[1][0] && !(wr_ok && a_rg == 4'h7) |=> flags_r[1][0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag lost");
  // source 0 wins over source 1, source 1 wins when 0 is idle
  property p_prio;
    |src_nxt[1:0] |=> IRQ_REQ_OUT &&
      IRQ_SRC_OUT == {4'h0, !$past(src_nxt[0])};
  endproperty
  a_prio: assert property (p_prio)
    else $error("wrong priority");
  property p_apb;
    setup |=> PREADY_OUT ##1 !PREADY_OUT;
  endproperty
  a_apb: assert property (p_apb)
    else $error("bad ready timing");
endmodule

/* File: ptu_pkg.sv */
// constants, types and register map of the six channel pulse timer unit
package ptu_pkg;
  localparam int NCH = 6;
  localparam int NPIN = 16;
  localparam int NSRC = 26;
  localparam int NSYNC = 20;
  // register index inside a channel window (byte address = index * 4)
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_IOCTL = 4'h1;
  localparam logic [3:0] R_COUNT = 4'h2;
  localparam logic [3:0] R_GRA = 4'h3;
  localparam logic [3:0] R_GRB = 4'h4;
  localparam logic [3:0] R_GRC = 4'h5;
  localparam logic [3:0] R_GRD = 4'h6;
  localparam logic [3:0] R_STATUS = 4'h7;
  localparam logic [3:0] R_INTEN = 4'h8;
  // global window: channel field value 6, register index 0
  localparam logic [2:0] CH_GLOBAL = 3'h6;
  localparam logic [3:0] R_START = 4'h0;
  localparam int START_LSB = 0;
  localparam int ADC_EN_LSB = 8;
  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] GREG_RST = 16'hFFFF;
  localparam logic [15:0] IOCTL_RST = 16'h0000;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // counter clock select
  localparam logic [2:0] CLK_INT = 3'h0;
  localparam logic [2:0] CLK_EXT_A = 3'h1;
  localparam logic [2:0] CLK_EXT_D = 3'h4;
  localparam logic [2:0] CLK_CASCADE = 3'h5;
  // counter clear select: 0 none, 1..4 general reg a..d
  localparam logic [2:0] CLR_NONE = 3'h0;
  localparam logic [2:0] CLR_GRD = 3'h4;
  // compare output action / capture edge select
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_LOW = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // flag bit positions in a channel status word
  localparam int FLG_OVF = 4;
  localparam int FLG_UDF = 5;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PWM1 = 2'b01,
    MODE_PWM2 = 2'b10,
    MODE_PHASE = 2'b11
  } ptu_mode_e;
  // channel control word, 13 bits
  typedef struct packed {
    logic buf_b;
    logic buf_a;
    logic [1:0] phase;
    ptu_mode_e mode;
    logic sync;
    logic [2:0] clr_sel;
    logic [2:0] clk_sel;
  } ptu_ctrl_s;
  localparam ptu_ctrl_s CTRL_RST = 13'h0000;
  // one nibble of the io control word per general register
  typedef struct packed {
    logic capture;
    logic init_lvl;
    logic [1:0] act;
  } ptu_io_s;
endpackage

/* File: ptu_far_model.sv */
// far side model: quadrature encoder and capture pin drivers
`timescale 1ns/1ps
module ptu_far_model (
  input wire logic clk_in,
  output logic [3:0] ext_clk_out,
  output logic [15:0] pin_out
);
  // idle encoder and pins held low
  initial begin
    ext_clk_out = 4'h0;
    pin_out = 16'h0000;
  end
  // n quadrature cycles on a/b, a leads b when fwd is set
  task automatic quad(input logic fwd, input int n);
    logic [7:0] w;
    int i;
    w = fwd ? 8'h2D : 8'h1E;
    for (i = 0; i < 4 * n; i++) begin
      repeat (8) @(posedge clk_in);
      ext_clk_out[1:0] <= w[2 * (i % 4) +: 2];
    end
  endtask
  // one pin level change after a rising edge
  task automatic pin(input int k, input logic v);
    @(posedge clk_in);
    pin_out[k] <= v;
  endtask
endmodule

/* File: tb_top.sv */
// self-checking bench of the pulse timer unit over apb
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, adc;
  logic adc_seen = 1'b0;
  logic [3:0] ext;
  logic [15:0] pin_m, pin_w, pout, poe, xfer;
  logic [25:0] irqf;
  logic [4:0] src;
  int num_errors = 0;
  int checks_done = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  // remembers any converter trigger pulse
  always @(posedge clk) begin
    if (adc === 1'b1) adc_seen <= 1'b1;
  end
  // pin wire: design drives where enabled, model elsewhere
  assign pin_w = (poe & pout) | (~poe & pin_m);
  ptu_top ptu_top_inst (.CLOCK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .EXT_CLOCK_IN(ext), .CAPOUT_PIN_IN(pin_w),
    .CAPOUT_PIN_OUT(pout), .CAPOUT_PIN_OE_OUT(poe), .IRQ_FLAGS_OUT(irqf),
    .IRQ_REQ_OUT(irq), .IRQ_SRC_OUT(src), .XFER_REQ_OUT(xfer),
    .ADC_TRIG_OUT(adc));
  ptu_far_model ptu_far_model_inst (.clk_in(clk), .ext_clk_out(ext),
    .pin_out(pin_m));
  // verdict and end of run
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one compare of a value seen against its expectation
  task automatic cmp(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [2:0] ch,
                     input logic [3:0] ix, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {ch, ix, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      close_out();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  // register write
  task automatic wr(input logic [2:0] ch, input logic [3:0] ix,
                    input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, ch, ix, d, q, e);
  endtask
  // register read with data and error compare
  task automatic rd(input logic [2:0] ch, input logic [3:0] ix,
                    input logic [31:0] x, input logic xe, input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, ch, ix, 32'h0000_0000, q, e);
    cmp(nm, x, q);
    cmp({nm, " err"}, {31'h0, xe}, {31'h0, e});
  endtask
  // bounded wait for masked pin outputs
  task automatic wait_pins(input logic [15:0] m, input logic [15:0] v);
    int n;
    for (n = 0; n < 100 && (pout & m) !== v; n++) @(posedge clk);
    cmp("pins", {16'h0, v}, {16'h0, pout & m});
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(3'h0, ptu_pkg::R_GRA, 32'h0000_FFFF, 1'b0, "gra0");
    rd(3'h0, ptu_pkg::R_COUNT, 32'h0, 1'b0, "count0");
    rd(3'h1, ptu_pkg::R_GRC, 32'h0, 1'b1, "grc1");
    // ch0 outputs: a high, b toggle from 1, c low from 1
    wr(3'h0, ptu_pkg::R_GRA, 32'h4);
    wr(3'h0, ptu_pkg::R_GRB, 32'h6);
    wr(3'h0, ptu_pkg::R_GRC, 32'h5);
    wr(3'h0, ptu_pkg::R_IOCTL, 32'h0572);
    wait_pins(16'h0007, 16'h0006);
    wr(ptu_pkg::CH_GLOBAL, ptu_pkg::R_START, 32'h101);
    wait_pins(16'h0007, 16'h0001);
    cmp("oe", 32'h7, {16'h0, poe});
    cmp("adc", 32'h1, {31'h0, adc_seen});
    wr(3'h0, ptu_pkg::R_INTEN, 32'h6);
    repeat (4) @(posedge clk);
    cmp("irq src", 32'h1, {27'h0, src});
    cmp("irq flags", 32'h6, {6'h0, irqf});
    cmp("irq", 32'h1, {31'h0, irq});
    cmp("xfer", 32'h6, {16'h0, xfer});
    rd(3'h0, ptu_pkg::R_STATUS, 32'h7, 1'b0, "status0");
    wr(3'h0, ptu_pkg::R_STATUS, 32'h7);
    rd(3'h0, ptu_pkg::R_STATUS, 32'h0, 1'b0, "status0 clr");
    cmp("irq off", 32'h0, {31'h0, irq});
    // ch1 capture on falling edge clears the stopped counter
    wr(3'h1, ptu_pkg::R_CTRL, 32'h08);
    wr(3'h1, ptu_pkg::R_COUNT, 32'h1234);
    wr(3'h1, ptu_pkg::R_IOCTL, 32'hA);
    ptu_far_model_inst.pin(4, 1'b1);
    repeat (10) @(posedge clk);
    rd(3'h1, ptu_pkg::R_GRA, 32'hFFFF, 1'b0, "rise");
    ptu_far_model_inst.pin(4, 1'b0);
    repeat (10) @(posedge clk);
    rd(3'h1, ptu_pkg::R_GRA, 32'h1234, 1'b0, "fall");
    rd(3'h1, ptu_pkg::R_COUNT, 32'h0, 1'b0, "clr cap");
    // ch3 buffered capture on both edges: old a moves into c
    wr(3'h3, ptu_pkg::R_CTRL, 32'h800);
    wr(3'h3, ptu_pkg::R_IOCTL, 32'hB);
    wr(3'h3, ptu_pkg::R_COUNT, 32'h55);
    ptu_far_model_inst.pin(8, 1'b1);
    repeat (10) @(posedge clk);
    wr(3'h3, ptu_pkg::R_COUNT, 32'h66);
    ptu_far_model_inst.pin(8, 1'b0);
    repeat (10) @(posedge clk);
    rd(3'h3, ptu_pkg::R_GRA, 32'h66, 1'b0, "cap a");
    rd(3'h3, ptu_pkg::R_GRC, 32'h55, 1'b0, "buf c");
    // ch1 phase counting, first variant, both directions
    wr(3'h1, ptu_pkg::R_CTRL, 32'h0180);
    wr(3'h1, ptu_pkg::R_COUNT, 32'h0);
    wr(ptu_pkg::CH_GLOBAL, ptu_pkg::R_START, 32'h3);
    ptu_far_model_inst.quad(1'b1, 2);
    repeat (8) @(posedge clk);
    rd(3'h1, ptu_pkg::R_COUNT, 32'h8, 1'b0, "up");
    ptu_far_model_inst.quad(1'b0, 1);
    repeat (8) @(posedge clk);
    rd(3'h1, ptu_pkg::R_COUNT, 32'h4, 1'b0, "down");
    // ch0 buffered compare: a match reloads a from c
    wr(3'h0, ptu_pkg::R_CTRL, 32'h800);
    wr(3'h0, ptu_pkg::R_GRC, 32'h9);
    wr(3'h0, ptu_pkg::R_COUNT, 32'h3);
    repeat (8) @(posedge clk);
    rd(3'h0, ptu_pkg::R_GRA, 32'h9, 1'b0, "reload");
    close_out();
  end
endmodule
